// [alr_pkg.sv]
// Shared constants and types for the ambient light readout block
package alr_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int FRAME_MS = 100;
    localparam int FRAME_CYC = FRAME_MS * (CLK_HZ / 1000);
    localparam int CONV_US = 300;
    localparam int CONV_CYC = CONV_US * (CLK_HZ / 1_000_000);
    localparam int MAX_AVG = 128;
    localparam int AVG_W = 3;
    localparam logic [6:0] DEV_ADDR = 7'h13;
    localparam logic [7:0] REG_CMD = 8'h80;
    localparam logic [7:0] REG_LED = 8'h83;
    localparam logic [7:0] REG_AMB = 8'h84;
    localparam logic [7:0] REG_RES_HI = 8'h85;
    localparam logic [7:0] REG_RES_LO = 8'h86;
    localparam logic [7:0] REG_AIR = 8'h8B;
    localparam int CMD_START = 4;
    localparam int CMD_BUSY = 5;
    localparam int CMD_READY = 6;
    localparam int AMB_CONT = 7;
    localparam logic [7:0] LED_RST = 8'h00;
    localparam logic [7:0] AMB_RST = 8'h00;
    localparam logic [7:0] PTR_RST = 8'h00;
    typedef enum logic [2:0] {
        I_IDLE, I_ADDR, I_AACK, I_WBYTE, I_WACK, I_RBYTE, I_RACK
    } alr_i2c_type;
    typedef enum logic [1:0] {Q_IDLE, Q_CONV, Q_WAIT} alr_seq_type;
endpackage

// [alr_seq.sv]
// Ambient light conversion sequencer with averaging
`timescale 1ns/1ps
module alr_seq import alr_pkg::*; #(
    parameter int FRAME = FRAME_CYC,
    parameter int CONV = CONV_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic cont,
    input wire logic [AVG_W-1:0] avg_exp,
    input wire logic [15:0] light,
    output logic busy,
    output logic sense_en,
    output logic done,
    output logic [15:0] result
);
    if (CONV < 1 || CONV * MAX_AVG > FRAME) begin : g_chk
        $error("Conversion time does not fit the frame");
    end

    alr_seq_type st;
    logic [31:0] tmr;
    logic [31:0] slot;
    logic [31:0] fr;
    logic [7:0] n;
    logic [22:0] sum;
    logic [AVG_W-1:0] exp_q;
    logic cont_q;

    wire [7:0] cnt_m1 = 8'((9'h001 << exp_q) - 9'h001);
    wire [31:0] slot_len = 32'(FRAME) >> exp_q;
    wire conv_end = st == Q_CONV && tmr == 32'(CONV - 1);
    wire last = n == cnt_m1;
    wire all_done = n > cnt_m1;
    wire slot_end = slot == slot_len - 32'h1;
    wire frame_end = fr == 32'(FRAME - 1);
    wire [22:0] sum_new = sum + 23'(light);

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= Q_IDLE;
            tmr <= 32'h0;
            slot <= 32'h0;
            fr <= 32'h0;
            n <= 8'h00;
            sum <= 23'h0;
            exp_q <= '0;
            cont_q <= 1'b0;
            busy <= 1'b0;
            sense_en <= 1'b0;
            done <= 1'b0;
            result <= 16'h0000;
        end else begin
            done <= 1'b0;
            unique case (st)
                Q_IDLE: if (start) begin
                    st <= Q_CONV;
                    exp_q <= avg_exp;
                    cont_q <= cont;
                    tmr <= 32'h0;
                    slot <= 32'h0;
                    fr <= 32'h0;
                    n <= 8'h00;
                    sum <= 23'h0;
                    busy <= 1'b1;
                    sense_en <= 1'b1;
                end
                Q_CONV: begin
                    tmr <= tmr + 32'h1;
                    slot <= slot + 32'h1;
                    fr <= fr + 32'h1;
                    if (conv_end) begin
                        sum <= sum_new;
                        n <= n + 8'h01;
                        sense_en <= 1'b0;
                        if (cont_q && last) begin
                            st <= Q_IDLE;
                            busy <= 1'b0;
                            done <= 1'b1;
                            result <= 16'(sum_new >> exp_q);
                        end else if (cont_q) begin
                            tmr <= 32'h0;
                            sense_en <= 1'b1;
                        end else if (frame_end) begin
                            // Packed slots end the frame on the last one
                            st <= Q_IDLE;
                            busy <= 1'b0;
                            done <= 1'b1;
                            result <= 16'(sum_new >> exp_q);
                        end else if (slot_end && !last) begin
                            // Slot no longer than a conversion: the wait
                            // state would miss its end and idle until the frame ends
                            slot <= 32'h0;
                            tmr <= 32'h0;
                            sense_en <= 1'b1;
                        end else begin
                            st <= Q_WAIT;
                        end
                    end
                end
                Q_WAIT: begin
                    slot <= slot + 32'h1;
                    fr <= fr + 32'h1;
                    if (frame_end) begin
                        st <= Q_IDLE;
                        busy <= 1'b0;
                        done <= 1'b1;
                        result <= 16'(sum >> exp_q);
                    end else if (slot_end && !all_done) begin
                        // Spread conversions evenly over the frame
                        slot <= 32'h0;
                        tmr <= 32'h0;
                        sense_en <= 1'b1;
                        st <= Q_CONV;
                    end
                end
                default: st <= Q_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_mid_conv;
        conv_end && cont_q && !last;
    endsequence
    property p_conv_len;
        $fell(sense_en) |-> $past(tmr) == 32'(CONV - 1);
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("bad conv length");
    property p_gapless;
        s_mid_conv |=> sense_en && st == Q_CONV && tmr == 32'h0;
    endproperty
    a_gapless: assert property (p_gapless) else $error("gap in cont mode");
    property p_std_wait;
        conv_end && !cont_q && !frame_end && !(slot_end && !last)
            |=> st == Q_WAIT;
    endproperty
    a_std_wait: assert property (p_std_wait) else $error("no frame wait");
    property p_std_pack;
        conv_end && !cont_q && slot_end && !last && !frame_end
            |=> st == Q_CONV && sense_en && tmr == 32'h0;
    endproperty
    a_std_pack: assert property (p_std_pack) else $error("slot lost");
    property p_std_frame;
        done && !cont_q |-> $past(fr) == 32'(FRAME - 1);
    endproperty
    a_std_frame: assert property (p_std_frame) else $error("early result");
    property p_avg_n;
        done |-> n == 8'(cnt_m1 + 8'h01);
    endproperty
    a_avg_n: assert property (p_avg_n) else $error("wrong average count");
    property p_cont_fast;
        done && cont_q |-> $past(conv_end);
    endproperty
    a_cont_fast: assert property (p_cont_fast) else $error("late result");
    property p_auto_idle;
        done |-> !busy && st == Q_IDLE && !sense_en;
    endproperty
    a_auto_idle: assert property (p_auto_idle) else $error("no standby");
endmodule // alr_seq

// [alr_top.sv]
// Two-wire register read/write path and ambient light sequencing top
`timescale 1ns/1ps
module alr_top import alr_pkg::*; #(
    parameter int FRAME_CYC_P = FRAME_CYC,
    parameter int CONV_CYC_P = CONV_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [15:0] light_level,
    output logic als_sense_en,
    output logic ir_sink_en,
    output logic standby
);
    logic rst_q1;
    logic rst_s;
    logic scl_q;
    logic sda_q;
    alr_i2c_type st;
    logic [2:0] bitc;
    logic got8;
    logic [7:0] sh;
    logic rw;
    logic first;
    logic nack;
    logic [7:0] ptr;
    logic [7:0] led_cur;
    logic [7:0] amb_cfg;
    logic ready;
    logic seq_start;
    logic seq_busy;
    logic seq_done;
    logic [15:0] res;
    logic [7:0] rd_data;
    logic [7:0] cmd_rd;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_q1 <= 1'b0;
            rst_s <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_s <= rst_q1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    wire i2c_start = scl && scl_q && sda_q && !sda_in;
    wire i2c_stop = scl && scl_q && !sda_q && sda_in;
    wire scl_rise = scl && !scl_q;
    wire scl_fall = !scl && scl_q;
    wire addr_hit = sh[7:1] == DEV_ADDR;
    wire byte_in = scl_fall && got8;
    wire ptr_wr = byte_in && st == I_WBYTE && first;
    wire data_wr = byte_in && st == I_WBYTE && !first;
    wire rd_last = scl_fall && st == I_RBYTE && bitc == 3'h7;
    wire wr_cmd = data_wr && ptr == REG_CMD;
    wire wr_led = data_wr && ptr == REG_LED;
    wire wr_amb = data_wr && ptr == REG_AMB;

    assign cmd_rd = (8'(ready) << CMD_READY) | (8'(seq_busy) << CMD_BUSY);
    // Reserved and unmapped pointers read as zero
    assign rd_data = ptr == REG_CMD ? cmd_rd :
                     ptr == REG_LED ? led_cur :
                     ptr == REG_AMB ? amb_cfg :
                     ptr == REG_RES_HI ? res[15:8] :
                     ptr == REG_RES_LO ? res[7:0] : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk or negedge rst_s) begin
        if (!rst_s) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl;
            sda_q <= sda_in;
        end
    end

    // Start and stop are taken from any state, so a repeated start works
    always_ff @(posedge ref_clk or negedge rst_s) begin
        if (!rst_s) begin
            st <= I_IDLE;
            bitc <= 3'h0;
            got8 <= 1'b0;
            sh <= 8'h00;
            rw <= 1'b0;
            first <= 1'b0;
            nack <= 1'b0;
            ptr <= PTR_RST;
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
        end else if (i2c_stop) begin
            st <= I_IDLE;
            sda_oe <= 1'b0;
        end else if (i2c_start) begin
            st <= I_ADDR;
            bitc <= 3'h0;
            got8 <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            if (scl_rise && (st == I_ADDR || st == I_WBYTE)) begin
                sh <= {sh[6:0], sda_in};
                bitc <= bitc + 3'h1;
                got8 <= bitc == 3'h7;
            end
            if (scl_rise && st == I_RACK) begin
                nack <= sda_in;
            end
            if (scl_fall) begin
                unique case (st)
                    I_ADDR: if (got8) begin
                        got8 <= 1'b0;
                        if (addr_hit) begin
                            st <= I_AACK;
                            rw <= sh[0];
                            sda_oe <= 1'b1;
                        end else begin
                            st <= I_IDLE;
                        end
                    end
                    I_AACK: if (rw) begin
                        st <= I_RBYTE;
                        sh <= rd_data;
                        sda_oe <= !rd_data[7];
                        bitc <= 3'h0;
                    end else begin
                        st <= I_WBYTE;
                        first <= 1'b1;
                        sda_oe <= 1'b0;
                        bitc <= 3'h0;
                    end
                    I_WBYTE: if (got8) begin
                        got8 <= 1'b0;
                        st <= I_WACK;
                        sda_oe <= 1'b1;
                        first <= 1'b0;
                        if (first) begin
                            ptr <= sh;
                        end else begin
                            ptr <= ptr + 8'h01;
                        end
                    end
                    I_WACK: begin
                        st <= I_WBYTE;
                        sda_oe <= 1'b0;
                        bitc <= 3'h0;
                    end
                    I_RBYTE: if (rd_last) begin
                        st <= I_RACK;
                        sda_oe <= 1'b0;
                        ptr <= ptr + 8'h01;
                    end else begin
                        bitc <= bitc + 3'h1;
                        sh <= {sh[6:0], 1'b0};
                        sda_oe <= !sh[6];
                    end
                    I_RACK: if (!nack) begin
                        st <= I_RBYTE;
                        sh <= rd_data;
                        sda_oe <= !rd_data[7];
                        bitc <= 3'h0;
                    end else begin
                        st <= I_IDLE;
                    end
                    I_IDLE: begin
                    end
                    default: st <= I_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk or negedge rst_s) begin
        if (!rst_s) begin
            led_cur <= LED_RST;
            amb_cfg <= AMB_RST;
            ready <= 1'b0;
            seq_start <= 1'b0;
            standby <= 1'b1;
            ir_sink_en <= 1'b0;
        end else begin
            seq_start <= wr_cmd && sh[CMD_START] && !seq_busy;
            if (wr_led) begin
                led_cur <= sh;
            end
            if (wr_amb) begin
                amb_cfg <= sh;
            end
            if (seq_done) begin
                ready <= 1'b1;
            end else if (seq_start) begin
                ready <= 1'b0;
            end
            standby <= !seq_busy && !seq_start;
            // Only a proximity cycle may sink current; the setting is
            // kept but never reaches the sink from here
            ir_sink_en <= 1'b0;
        end
    end

    alr_seq #(
        .FRAME(FRAME_CYC_P),
        .CONV(CONV_CYC_P)
    ) alr_seq_i (
        .clk(ref_clk),
        .rst_n(rst_s),
        .start(seq_start),
        .cont(amb_cfg[AMB_CONT]),
        .avg_exp(amb_cfg[AVG_W-1:0]),
        .light(light_level),
        .busy(seq_busy),
        .sense_en(als_sense_en),
        .done(seq_done),
        .result(res)
    );

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_s);

    property p_restart;
        i2c_start && !i2c_stop |=> st == I_ADDR && !sda_oe;
    endproperty
    a_restart: assert property (p_restart) else $error("start missed");
    property p_ptr_load;
        ptr_wr |=> ptr == $past(sh) && st == I_WACK;
    endproperty
    a_ptr_load: assert property (p_ptr_load) else $error("ptr not set");
    property p_read_first;
        scl_fall && st == I_AACK && rw && !i2c_start && !i2c_stop
            |=> sh == $past(rd_data) && sda_oe == !sh[7];
    endproperty
    a_read_first: assert property (p_read_first) else $error("bad data");
    property p_ptr_inc;
        rd_last && !i2c_start && !i2c_stop |=> ptr == $past(ptr) + 8'h01;
    endproperty
    a_ptr_inc: assert property (p_ptr_inc) else $error("ptr not advanced");
    property p_res_hi;
        ptr == REG_RES_HI |-> rd_data == res[15:8];
    endproperty
    a_res_hi: assert property (p_res_hi) else $error("wrong high byte");
    property p_res_lo;
        ptr == REG_RES_LO |-> rd_data == res[7:0];
    endproperty
    a_res_lo: assert property (p_res_lo) else $error("wrong low byte");
    property p_idle;
        standby |-> !als_sense_en && !seq_busy;
    endproperty
    a_idle: assert property (p_idle) else $error("active in standby");
    property p_sink_off;
        standby |-> !ir_sink_en;
    endproperty
    a_sink_off: assert property (p_sink_off) else $error("sink on");
    property p_addr_ack;
        scl_fall && st == I_ADDR && got8 && addr_hit
            |=> st == I_AACK && sda_oe;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("no ack");
    property p_addr_miss;
        scl_fall && st == I_ADDR && got8 && !addr_hit
            |=> st == I_IDLE && !sda_oe;
    endproperty
    a_addr_miss: assert property (p_addr_miss) else $error("acked");
    property p_ptr_keep;
        !(byte_in && st == I_WBYTE) && !rd_last |=> $stable(ptr);
    endproperty
    a_ptr_keep: assert property (p_ptr_keep) else $error("ptr moved");
    property p_rd_shift;
        scl_fall && st == I_RBYTE && !rd_last
            |=> sh == 8'($past(sh) << 1) && sda_oe == !sh[7];
    endproperty
    a_rd_shift: assert property (p_rd_shift) else $error("bad bit");
    sequence s_go;
        wr_cmd && sh[CMD_START] && !seq_busy;
    endsequence
    sequence s_woken;
        !standby && seq_busy;
    endsequence
    property p_wake;
        s_go |=> seq_start ##1 s_woken;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake");
endmodule // alr_top

// [alr_host.sv]
// Two-wire bus host model that drives the sensor's serial port
`timescale 1ns/1ps
module alr_host (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_oe
);
    localparam int HALF = 4;
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Also serves as repeated start: sda is released while scl is low
    task automatic start_cond();
        wait_cyc(1);
        sda_oe = 1'b0;
        wait_cyc(HALF);
        scl = 1'b1;
        wait_cyc(HALF);
        sda_oe = 1'b1;
        wait_cyc(HALF);
        scl = 1'b0;
    endtask
    task automatic stop_cond();
        wait_cyc(1);
        sda_oe = 1'b1;
        wait_cyc(HALF);
        scl = 1'b1;
        wait_cyc(HALF);
        sda_oe = 1'b0;
        wait_cyc(HALF);
    endtask
    // Data changes only while scl is low, well ahead of the rise
    task automatic xfer_bit(input logic b, output logic r);
        wait_cyc(1);
        sda_oe = ~b;
        wait_cyc(HALF);
        scl = 1'b1;
        wait_cyc(2);
        r = sda;
        wait_cyc(HALF);
        scl = 1'b0;
    endtask
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xfer_bit(d[i], r);
        xfer_bit(1'b1, r);
        ack = ~r;
    endtask
    // Last byte is answered with a release, which ends the read
    task automatic recv_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) xfer_bit(1'b1, d[i]);
        xfer_bit(last, r);
    endtask
endmodule // alr_host

// [alr_top_tb.sv]
// Self-checking bench for the ambient light readout top
`timescale 1ns/1ps
module alr_top_tb import alr_pkg::*;;
    localparam int FRAME = 2560;
    localparam int CONV = 20;
    typedef struct {
        logic [7:0] ptr;
        logic [7:0] wd;
        logic [7:0] exp;
        logic rep;
    } alr_row_type;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic scl;
    logic host_oe;
    logic sda_out;
    logic sda_oe;
    logic als_sense_en;
    logic ir_sink_en;
    logic standby;
    logic ir_seen = 1'b0;
    logic [15:0] light_level;
    logic [15:0] d;
    logic a;
    wire sda_line;
    int cyc_hi;
    int idx;
    int run;
    int max_run;
    int rises;
    int lo_cyc;
    int miscompares;
    int checked;
    logic [15:0] lt [5] = '{16'h0000, 16'h1000, 16'h2000, 16'h3001, 16'h4002};
    // Reserved 8Bh is never addressed by the host
    alr_row_type rows [5] = '{
        '{8'h83, 8'hA5, 8'hA5, 1'b0}, '{8'h84, 8'h3C, 8'h3C, 1'b1},
        '{8'h85, 8'h77, 8'h00, 1'b0}, '{8'h90, 8'h5A, 8'h00, 1'b1},
        '{8'h80, 8'h00, 8'h00, 1'b0}};
    always #25 ref_clk = ~ref_clk;
    // Pull-up wire: low when either party pulls
    assign sda_line = ~(sda_oe | host_oe);
    // Sample steps per conversion, then holds its last value
    assign idx = (cyc_hi + CONV / 2) / CONV;
    assign light_level = lt[idx > 4 ? 4 : idx];
    alr_top #(.FRAME_CYC_P(FRAME), .CONV_CYC_P(CONV)) alr_top_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .scl(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .light_level(light_level),
        .als_sense_en(als_sense_en), .ir_sink_en(ir_sink_en),
        .standby(standby));
    alr_host alr_host_i (.clk(ref_clk), .sda(sda_line), .scl(scl),
        .sda_oe(host_oe));
    ////////////////////////////////////////////////////////////////////////
    always @(negedge ref_clk) begin
        if (als_sense_en === 1'b1) begin
            cyc_hi <= cyc_hi + 1;
            run <= run + 1;
            if (run + 1 > max_run) max_run <= run + 1;
            if (run == 0) rises <= rises + 1;
        end else begin
            run <= 0;
        end
        if (standby === 1'b0) lo_cyc <= lo_cyc + 1;
        if (ir_sink_en !== 1'b0) ir_seen <= 1'b1;
    end
    // Cleared on the rising edge to stay clear of the monitor's updates
    task automatic clr_mon();
        @(posedge ref_clk);
        cyc_hi = 0;
        max_run = 0;
        rises = 0;
        lo_cyc = 0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got,
                exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] ptr, input logic [7:0] wd);
        alr_host_i.start_cond();
        alr_host_i.send_byte(8'h26, a);
        alr_host_i.send_byte(ptr, a);
        alr_host_i.send_byte(wd, a);
        alr_host_i.stop_cond();
    endtask
    // Pointer-only write, then stop and start or a repeated start
    task automatic rd_reg(input logic [7:0] ptr, input logic rep,
        input int n, output logic [15:0] q);
        logic [7:0] b;
        q = '0;
        alr_host_i.start_cond();
        alr_host_i.send_byte(8'h26, a);
        alr_host_i.send_byte(ptr, a);
        if (!rep) alr_host_i.stop_cond();
        alr_host_i.start_cond();
        alr_host_i.send_byte(8'h27, a);
        chk(a, 1'b1);
        for (int i = 0; i < n; i++) begin
            alr_host_i.recv_byte(i == n - 1, b);
            q = {q[7:0], b};
        end
        alr_host_i.stop_cond();
    endtask
    task automatic wait_idle(input int lim);
        for (int k = 0; k < lim && standby !== 1'b1; k++) @(negedge ref_clk);
    endtask
    task automatic summarize();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #2_000_000;
        miscompares++;
        summarize();
    end
    initial begin
        repeat (20) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        chk(standby, 1'b1);
        foreach (rows[i]) begin
            wr_reg(rows[i].ptr, rows[i].wd);
            rd_reg(rows[i].ptr, rows[i].rep, 1, d);
            chk(d, {8'h00, rows[i].exp});
        end
        alr_host_i.start_cond();
        alr_host_i.send_byte(8'h30, a);
        alr_host_i.stop_cond();
        chk(a, 1'b0);
        rd_reg(8'h83, 1'b1, 2, d);
        chk(d, 16'hA53C);
        // Standard frame, four conversions, emitter set to full
        wr_reg(8'h84, 8'h02);
        wr_reg(8'h83, 8'hFF);
        clr_mon();
        wr_reg(8'h80, 8'h10);
        chk(standby, 1'b0);
        for (int k = 0; k < FRAME && !(rises == 3 && run == 0); k++)
            @(negedge ref_clk);
        rd_reg(8'h85, 1'b0, 1, d);
        chk(d, 16'h0000);
        wait_idle(FRAME);
        chk(lo_cyc >= FRAME && lo_cyc <= FRAME + 3, 1'b1);
        chk(rises, 4);
        chk(max_run, CONV);
        chk(ir_seen, 1'b0);
        rd_reg(8'h85, 1'b1, 2, d);
        chk(d, 16'h2800);
        rd_reg(8'h80, 1'b0, 1, d);
        chk(d, 16'h0040);
        // Back-to-back pair of conversions
        wr_reg(8'h84, 8'h81);
        clr_mon();
        wr_reg(8'h80, 8'h10);
        wait_idle(FRAME);
        chk(max_run, 2 * CONV);
        chk(rises, 1);
        chk(lo_cyc >= 2 * CONV && lo_cyc <= 2 * CONV + 4, 1'b1);
        rd_reg(8'h85, 1'b0, 2, d);
        chk(d, 16'h1800);
        // Slots as long as a conversion: 128 packed into the frame
        wr_reg(8'h84, 8'h07);
        clr_mon();
        wr_reg(8'h80, 8'h10);
        wait_idle(FRAME);
        chk(lo_cyc >= FRAME && lo_cyc <= FRAME + 3, 1'b1);
        chk(max_run, FRAME);
        rd_reg(8'h85, 1'b1, 2, d);
        chk(d, 16'h3F41);
        // Reset in mid-run clears stored settings
        wr_reg(8'h80, 8'h10);
        chk(als_sense_en, 1'b1);
        @(negedge ref_clk);
        rst_n = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk({sda_out, sda_oe, standby, als_sense_en}, 4'b0010);
        rst_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        rd_reg(8'h83, 1'b1, 2, d);
        chk(d, 16'h0000);
        rd_reg(8'h80, 1'b0, 1, d);
        chk(d, 16'h0000);
        summarize();
    end
endmodule // alr_top_tb
